// file: bench/otss_relay_model.sv
/*
  Controller-side model that reads the output terminals like relay coils.
  Assumes terminals are levels on mclk.
*/
`timescale 1ns/1ps
module otss_relay_model #(
  parameter int NUM_TERM = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [NUM_TERM-1:0] terminal,
  output logic [NUM_TERM-1:0] seen_q
);
  // A contact follows its coil a clock late, so checks here see the level the terminal had one edge earlier.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) seen_q <= '0;
    else seen_q <= terminal;
  end
endmodule : otss_relay_model

// file: bench/otss_top_assertions.sv
/*
  Port checker for otss_top, bound into every instance.
  Assumes three terminals and shadows the code and width registers from the strobes.
*/
`timescale 1ns/1ps
module otss_top_assertions #(
  parameter int NUM_TERM = 3
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire otss_pkg::otss_drive_t drive,
  input wire otss_pkg::otss_restart_t restart,
  input wire logic [NUM_TERM-1:0] terminal,
  input wire logic irq
);
  import otss_pkg::*;
  logic [7:0] code_q [3];
  logic [15:0] width_q;
  wire [16:0] outMag = {1'b0, drive.outFreq[15] ? 16'h0000 - drive.outFreq : drive.outFreq};
  wire [16:0] refMag = {1'b0, drive.freqRef[15] ? 16'h0000 - drive.freqRef : drive.freqRef};
  wire agree = (outMag + {1'b0, width_q} >= refMag) && (outMag <= refMag + {1'b0, width_q});
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      code_q <= '{CODE_RST, CODE_RST, CODE_RST};
      width_q <= FREQ_RST;
    end else if (ce && regWr) begin
      for (int i = 0; i < 3; i++) begin
        if (regAddr == ADDR_CODE_BASE + 8'(4 * i)) code_q[i] <= regWdata[7:0];
      end
      if (regAddr == ADDR_WIDTH) width_q <= regWdata[15:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_rd_idle; ce && !regRd |=> regRdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; ce && regRd && regAddr == 8'h30 |=> regRdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_unused; ce && code_q[0] == CODE_UNUSED |=> !terminal[0]; endproperty
  a_unused: assert property (p_unused) else $error("unused terminal driven");
  property p_bb; ce && code_q[0] == CODE_BASEBLOCK_NC |=> terminal[0] == !$past(drive.baseblock);
  endproperty
  a_bb: assert property (p_bb) else $error("baseblock terminal wrong");
  property p_agree; ce && code_q[2] == CODE_SPEED_AGREE2 |=> terminal[2] == $past(agree); endproperty
  a_agree: assert property (p_agree) else $error("speed agree terminal wrong");
  property p_rev;
    ce && code_q[1] == CODE_REVERSE ##1 ce && code_q[1] == CODE_REVERSE
      |=> terminal[1] == $past(drive.outFreq[15], 2);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse terminal wrong");
  property p_mask; ce && regWr && regAddr == ADDR_MASK && regWdata == 32'h0 ##1 ce |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with empty mask");
  property p_try;
    $rose(terminal[1]) && $past(code_q[1]) == CODE_AUTO_RESTART
      && $past(code_q[1], 2) == CODE_AUTO_RESTART |-> $past(restart.faultDetect, 2);
  endproperty
  a_try: assert property (p_try) else $error("restart flag without fault");
  property p_clr;
    ce && code_q[1] == CODE_AUTO_RESTART && restart.faultCleared && !restart.faultDetect
      ##1 ce && code_q[1] == CODE_AUTO_RESTART |=> !terminal[1];
  endproperty
  a_clr: assert property (p_clr) else $error("restart flag kept after clear");
  c_bb: cover property (terminal[0] && code_q[0] == CODE_BASEBLOCK_NC);
  c_irq: cover property (irq);
  c_try: cover property (terminal[1] && code_q[1] == CODE_AUTO_RESTART);
endmodule : otss_top_assertions
bind otss_top otss_top_assertions #(.NUM_TERM(NUM_TERM)) u_chk (.mclk(mclk), .rstn(rstn),
  .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .drive(drive), .restart(restart), .terminal(terminal), .irq(irq));

// file: bench/test_output_terminal_status_select.sv
/*
  Self-checking bench for otss_top through its register port and drive samples.
  Assumes the relay model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_output_terminal_status_select;
  import otss_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [2:0] terminal;
  logic [2:0] seen;
  logic irq;
  otss_drive_t drive = '0;
  otss_restart_t restart = '0;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] tOut [7] = '{16'h0028, 16'h003D, 16'h0037, 16'h0032, 16'h0028, 16'hFFC3, 16'h0028};
  logic [15:0] tRef [7] = '{16'h0028, 16'h003D, 16'h0046, 16'h0032, 16'h0028, 16'hFFC3, 16'h0028};
  logic tBb [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [2:0] tExp [7] = '{3'h5, 3'h2, 3'h2, 3'h7, 3'h5, 3'h1, 3'h5};
  otss_top #(.NUM_TERM(3), .TICK_CYCLES(10)) DUT (.mclk(mclk), .rstn(rstn), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .drive(drive), .restart(restart), .terminal(terminal), .irq(irq));
  otss_relay_model #(.NUM_TERM(3)) relay (.mclk(mclk), .rstn(rstn), .terminal(terminal),
    .seen_q(seen));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // The whole sequence needs well under a thousand cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      results();
    end
  end
  task automatic results;
    $display("mismatches=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  task automatic drv(input logic [15:0] o, r, tq, input logic bb, input logic [2:0] e);
    @(posedge mclk);
    drive <= '{outFreq: o, freqRef: r, torque: tq, baseblock: bb};
    settle();
    `CHK(seen, e)
  endtask : drv
  task automatic pulse(input otss_restart_t p);
    @(posedge mclk);
    restart <= p;
    @(posedge mclk);
    restart <= '0;
  endtask : pulse
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(ADDR_CODE_BASE, 32'h0000000F);
    rd(ADDR_DETSEL, 32'h0);
    rd(ADDR_RSTLIMIT, 32'h3);
    rd(8'h30, 32'h0);
    wr(ADDR_WIDTH, 32'h0A);
    wr(ADDR_CODE_BASE, 32'h1B);
    wr(ADDR_CODE_BASE + 8'h04, 32'h1A);
    wr(ADDR_CODE_BASE + 8'h08, 32'h13);
    drv(16'hFF9C, 16'hFF97, 16'h0, 1'b0, 3'h7);
    drv(16'h0064, 16'hFF97, 16'h0, 1'b1, 3'h4);
    drv(16'h0078, 16'hFF97, 16'h0, 1'b0, 3'h1);
    wr(ADDR_LEVEL, 32'h32);
    wr(ADDR_DETSEL, 32'h1);
    wr(ADDR_CODE_BASE, 32'h15);
    wr(ADDR_CODE_BASE + 8'h04, 32'h16);
    wr(ADDR_CODE_BASE + 8'h08, 32'h14);
    for (int i = 0; i < 7; i++) begin
      drv(tOut[i], tRef[i], 16'h0, tBb[i], tExp[i]);
    end
    rd(ADDR_TERM, 32'h5);
    wr(ADDR_LEVEL, 32'hFFCE);
    rd(ADDR_LEVEL, 32'h0000FFCE);
    drv(16'hFFC3, 16'hFFC3, 16'h0, 1'b0, 3'h2);
    drv(16'h003D, 16'h003D, 16'h0, 1'b0, 3'h1);
    drv(16'hFFD3, 16'hFFD3, 16'h0, 1'b0, 3'h5);
    wr(ADDR_LEVEL, 32'h32);
    wr(ADDR_DETSEL, 32'h0);
    drv(16'h0028, 16'h0028, 16'h0, 1'b1, 3'h4);
    rd(ADDR_STATUS, 32'h8);
    wr(ADDR_STATUS, 32'hF);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_CODE_BASE, 32'h18);
    wr(ADDR_TQLEVEL, 32'h64);
    wr(ADDR_TQTIME, 32'h2);
    wr(ADDR_TQSEL, 32'h1);
    drv(16'h0028, 16'h0028, 16'h0096, 1'b1, 3'h5);
    `CHK(irq, 1'b1)
    wr(ADDR_STATUS, 32'h1);
    settle();
    `CHK(irq, 1'b0)
    wr(ADDR_TQSEL, 32'h5);
    drv(16'h0028, 16'h0028, 16'h0032, 1'b1, 3'h4);
    repeat (40) @(posedge mclk);
    #1;
    `CHK(terminal[0], 1'b1)
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_STATUS, 32'hF);
    wr(ADDR_CODE_BASE + 8'h04, 32'h1E);
    pulse(2'b10);
    settle();
    `CHK(terminal[1], 1'b1)
    rd(ADDR_RSTCOUNT, 32'h1);
    pulse(2'b01);
    settle();
    `CHK(terminal[1], 1'b0)
    rd(ADDR_STATUS, 32'h2);
    repeat (3) pulse(2'b10);
    settle();
    `CHK(terminal[1], 1'b1)
    pulse(2'b10);
    settle();
    `CHK(terminal[1], 1'b0)
    rd(ADDR_STATUS, 32'h6);
    // With the clock enable low a band exit must not reach the terminal.
    @(posedge mclk);
    ce <= 1'b0;
    drive.outFreq <= 16'h0064;
    settle();
    `CHK(terminal[2], 1'b1)
    @(posedge mclk);
    ce <= 1'b1;
    settle();
    `CHK(terminal[2], 1'b0)
    results();
  end
endmodule : test_output_terminal_status_select

// file: common/otss_pkg.sv
/*
  Shared constants and types for the output terminal status selector: register
  byte addresses, setting codes, reset values, interrupt bit positions, timing
  and the packed carriers for the drive samples and the fault restart events.
  Assumes a 100 MHz control clock and a register port with word-aligned addresses.
*/
package otss_pkg;

  localparam int FW = 16;
  localparam int CODE_W = 8;
  localparam int STAT_W = 4;

  // Register byte addresses, one 32-bit word each.
  localparam logic [7:0] ADDR_LEVEL = 8'h00;
  localparam logic [7:0] ADDR_WIDTH = 8'h04;
  localparam logic [7:0] ADDR_DETSEL = 8'h08;
  localparam logic [7:0] ADDR_TQSEL = 8'h0C;
  localparam logic [7:0] ADDR_TQLEVEL = 8'h10;
  localparam logic [7:0] ADDR_TQTIME = 8'h14;
  localparam logic [7:0] ADDR_RSTLIMIT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_TERM = 8'h24;
  localparam logic [7:0] ADDR_RSTCOUNT = 8'h28;
  localparam logic [7:0] ADDR_CODE_BASE = 8'h40;

  // Terminal setting codes.
  localparam logic [CODE_W-1:0] CODE_UNUSED = 8'h0F;
  localparam logic [CODE_W-1:0] CODE_SPEED_AGREE2 = 8'h13;
  localparam logic [CODE_W-1:0] CODE_USER_AGREE2 = 8'h14;
  localparam logic [CODE_W-1:0] CODE_FREQ_DET3 = 8'h15;
  localparam logic [CODE_W-1:0] CODE_FREQ_DET4 = 8'h16;
  localparam logic [CODE_W-1:0] CODE_TORQUE_DET2 = 8'h18;
  localparam logic [CODE_W-1:0] CODE_REVERSE = 8'h1A;
  localparam logic [CODE_W-1:0] CODE_BASEBLOCK_NC = 8'h1B;
  localparam logic [CODE_W-1:0] CODE_AUTO_RESTART = 8'h1E;

  // Reset values, plus the detect-always and undertorque select values.
  localparam logic [CODE_W-1:0] CODE_RST = CODE_UNUSED;
  localparam logic DETSEL_RST = 1'b0;
  localparam logic DETSEL_ALWAYS = 1'b1;
  localparam logic [3:0] TQSEL_RST = 4'h0;
  localparam logic [3:0] TQSEL_UNDER = 4'h5;
  localparam logic [7:0] RSTLIMIT_RST = 8'h03;
  localparam logic [FW-1:0] FREQ_RST = 16'h0000;

  // Interrupt status bit positions.
  localparam int STAT_TQ2 = 0;
  localparam int STAT_RST_OK = 1;
  localparam int STAT_RST_GIVEUP = 2;
  localparam int STAT_REVERSE = 3;

  // Torque detection time counts in units of 1 ms.
  localparam int CLK_MHZ = 100;
  localparam int TQ_UNIT_US = 1000;
  localparam int TQ_TICK_CYCLES = TQ_UNIT_US * CLK_MHZ;

  typedef struct packed {
    logic signed [FW-1:0] outFreq;
    logic signed [FW-1:0] freqRef;
    logic [FW-1:0] torque;
    logic baseblock;
  } otss_drive_t;

  typedef struct packed {
    logic faultDetect;
    logic faultCleared;
  } otss_restart_t;

  typedef enum logic [0:0] {
    RS_IDLE = 1'b0,
    RS_TRYING = 1'b1
  } otss_rstate_t;

endpackage : otss_pkg

// file: logic/otss_top.sv
/*
  Output terminal status selector: drives each multi-function output terminal
  from the condition picked by that terminal's setting code, with registers,
  interrupt status and mask reached over a plain strobe port.
  Assumes all drive samples and restart events come from logic on mclk.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
// Summary of operation
// RL1 - Code 13: output frequency within reference band.
// RL2 - Code 13 compares magnitudes, both directions alike.
// RL3 - Code 14: inside level band and reference band.
// RL4 - Codes 14-16 use signed level, one direction.
// RL5 - Code 15: off above level+width until level.
// RL6 - Detect select 0 blanks code 15 in baseblock.
// RL7 - Code 16: on above level until level-width.
// RL8 - Code 18: overtorque, or timed undertorque.
// RL9 - Torque select five or more means undertorque.
// RL10 - Code 1A: on while running in reverse.
// RL11 - Code 1B: off during baseblock, else on.
// RL12 - Code 1E: on while auto restart tries.
// RL13 - Code 1E off when restart clears fault.
// RL14 - Code 1E off when attempts hit limit.
// RL15 - Code F: terminal driven by no condition.
// RL16 - Per-terminal code register, re-evaluated every cycle.
`timescale 1ns/1ps
module otss_top #(
  parameter int NUM_TERM = 3,
  parameter int TICK_CYCLES = otss_pkg::TQ_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire otss_pkg::otss_drive_t drive,
  input wire otss_pkg::otss_restart_t restart,
  output logic [NUM_TERM-1:0] terminal,
  output logic irq
);
  import otss_pkg::*;

  localparam int EW = FW + 2;

  logic signed [FW-1:0] levelQ;
  logic [FW-1:0] widthQ;
  logic detSelQ;
  logic [3:0] tqSelQ;
  logic [FW-1:0] tqLevelQ;
  logic [FW-1:0] tqTimeQ;
  logic [7:0] rstLimitQ;
  logic [7:0] rstCountQ, rstCountD;
  logic [STAT_W-1:0] statusQ, statusD, maskQ;
  logic freq3OffQ, freq4OnQ, tq2Q, reverseQ;
  logic [16:0] prescQ;
  logic [FW-1:0] msCountQ;
  otss_rstate_t rstStateQ, rstStateD;
  logic [CODE_W-1:0] codeQ [NUM_TERM];

  // Register decode.
  wire wrLevel = regWr && regAddr == ADDR_LEVEL;
  wire wrWidth = regWr && regAddr == ADDR_WIDTH;
  wire wrDetSel = regWr && regAddr == ADDR_DETSEL;
  wire wrTqSel = regWr && regAddr == ADDR_TQSEL;
  wire wrTqLevel = regWr && regAddr == ADDR_TQLEVEL;
  wire wrTqTime = regWr && regAddr == ADDR_TQTIME;
  wire wrRstLimit = regWr && regAddr == ADDR_RSTLIMIT;
  wire wrStatus = regWr && regAddr == ADDR_STATUS;
  wire wrMask = regWr && regAddr == ADDR_MASK;
  wire [7:0] codeOffset = regAddr - ADDR_CODE_BASE;
  wire [5:0] codeIdx = codeOffset[7:2];
  wire codeHit = regAddr >= ADDR_CODE_BASE && int'(codeIdx) < NUM_TERM;

  // Frequency arithmetic, widened so no sum or magnitude overflows.
  wire signed [EW-1:0] fo = EW'(drive.outFreq);
  wire signed [EW-1:0] fr = EW'(drive.freqRef);
  wire signed [EW-1:0] lvl = EW'(levelQ);
  wire signed [EW-1:0] wd = $signed({2'b00, widthQ});
  wire signed [EW-1:0] foAbs = fo < 0 ? -fo : fo;
  wire signed [EW-1:0] frAbs = fr < 0 ? -fr : fr;
  wire levelNeg = lvl < 0;
  // A negative level mirrors the comparisons so detection happens in reverse only.
  wire signed [EW-1:0] foDir = levelNeg ? -fo : fo; // RL4
  wire signed [EW-1:0] lvlMag = levelNeg ? -lvl : lvl; // RL4

  wire speedAgree2 = foAbs >= frAbs - wd && foAbs <= frAbs + wd; // RL1 RL2
  wire inLevelBand = fo >= lvl - wd && fo <= lvl + wd; // RL3 RL4
  wire inRefBand = fo >= fr - wd && fo <= fr + wd; // RL3
  wire userAgree2 = inLevelBand && inRefBand; // RL3
  wire freq3Blank = detSelQ == DETSEL_RST && drive.baseblock; // RL6
  wire freq3Out = !freq3OffQ && !freq3Blank; // RL5 RL6
  wire freq3OffD = foDir > lvlMag + wd ? 1'b1 : (foDir <= lvlMag ? 1'b0 : freq3OffQ); // RL5
  wire freq4OnD = foDir > lvlMag ? 1'b1 : (foDir <= lvlMag - wd ? 1'b0 : freq4OnQ); // RL7

  // Torque detection 2.
  wire tqOverMode = tqSelQ != TQSEL_RST && tqSelQ < TQSEL_UNDER;
  wire tqUnderMode = tqSelQ >= TQSEL_UNDER; // RL9
  wire tqOver = tqOverMode && drive.torque > tqLevelQ; // RL8
  wire tqLow = tqUnderMode && drive.torque < tqLevelQ; // RL9
  wire msTick = tqLow && int'(prescQ) == TICK_CYCLES - 1;
  wire tqUnder = tqLow && msCountQ > tqTimeQ; // RL8 RL9
  wire tq2D = tqOver || tqUnder; // RL8

  wire reverseD = fo < 0; // RL10
  wire baseblockNc = !drive.baseblock; // RL11

  // Fault restart sequencing.
  wire atLimit = rstCountQ >= rstLimitQ;
  wire rstTrying = rstStateQ == RS_TRYING; // RL12
  wire rstSuccess = rstTrying && restart.faultCleared; // RL13
  wire rstGiveUp = restart.faultDetect && atLimit; // RL14

  always_comb begin
    rstStateD = rstStateQ;
    rstCountD = rstCountQ;
    unique case (rstStateQ)
      RS_IDLE: begin
        if (restart.faultDetect && !atLimit) begin
          rstStateD = RS_TRYING; // RL12
          rstCountD = rstCountQ + 8'h01;
        end
      end
      RS_TRYING: begin
        if (restart.faultCleared) begin
          rstStateD = RS_IDLE; // RL13
          rstCountD = 8'h00;
        end else if (restart.faultDetect) begin
          if (atLimit) begin
            rstStateD = RS_IDLE; // RL14
          end else begin
            rstCountD = rstCountQ + 8'h01;
          end
        end
      end
    endcase
  end

  // Interrupt events; a set in the cycle of a clear wins.
  wire [STAT_W-1:0] events = {reverseD && !reverseQ, rstGiveUp, rstSuccess, tq2D && !tq2Q};
  wire [STAT_W-1:0] clearBits = wrStatus ? regWdata[STAT_W-1:0] : {STAT_W{1'b0}};
  assign statusD = (statusQ & ~clearBits) | events;

  // Every condition a terminal can show, packed in the order the selector reads them.
  wire [7:0] conds = {rstTrying, baseblockNc, reverseQ, tq2Q, freq4OnQ, freq3Out,
    userAgree2, speedAgree2};

  // Condition selected by a setting code. The conditions come in as an argument so
  // that the continuous assignment calling this re-evaluates whenever any of them moves.
  function automatic logic selectCond(
    input logic [CODE_W-1:0] code,
    input logic [7:0] cv
  );
    logic c;
    c = 1'b0;
    case (code)
      CODE_SPEED_AGREE2: c = cv[0]; // RL1
      CODE_USER_AGREE2: c = cv[1]; // RL3
      CODE_FREQ_DET3: c = cv[2]; // RL5
      CODE_FREQ_DET4: c = cv[3]; // RL7
      CODE_TORQUE_DET2: c = cv[4]; // RL8
      CODE_REVERSE: c = cv[5]; // RL10
      CODE_BASEBLOCK_NC: c = cv[6]; // RL11
      CODE_AUTO_RESTART: c = cv[7]; // RL12
      default: c = 1'b0; // RL15
    endcase
    return c;
  endfunction : selectCond

  // Per-terminal write enables and next terminal levels.
  logic [NUM_TERM-1:0] codeWr;
  logic [NUM_TERM-1:0] termD;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++) begin : gTerm
      assign codeWr[gi] = regWr && codeHit && int'(codeIdx) == gi;
      assign termD[gi] = selectCond(codeQ[gi], conds); // RL16
    end
  endgenerate

  // Setting code registers, one per terminal.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        codeQ[i] <= CODE_RST;
      end
    end else if (ce) begin
      for (int i = 0; i < NUM_TERM; i++) begin
        if (codeWr[i]) begin
          codeQ[i] <= regWdata[CODE_W-1:0]; // RL16
        end
      end
    end
  end

  // All terminals share one flop bank so each output has a single driver.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      terminal <= {NUM_TERM{1'b0}};
    end else if (ce) begin
      terminal <= termD; // RL16
    end
  end

  // Read data mux.
  wire [31:0] termWord = 32'(terminal);
  wire [31:0] codeWord = codeHit ? 32'(codeQ[codeIdx[$clog2(NUM_TERM+1)-1:0]]) : 32'h00000000;
  wire [31:0] rdMux =
    regAddr == ADDR_LEVEL ? 32'(unsigned'(levelQ)) :
    regAddr == ADDR_WIDTH ? 32'(widthQ) :
    regAddr == ADDR_DETSEL ? 32'(detSelQ) :
    regAddr == ADDR_TQSEL ? 32'(tqSelQ) :
    regAddr == ADDR_TQLEVEL ? 32'(tqLevelQ) :
    regAddr == ADDR_TQTIME ? 32'(tqTimeQ) :
    regAddr == ADDR_RSTLIMIT ? 32'(rstLimitQ) :
    regAddr == ADDR_STATUS ? 32'(statusQ) :
    regAddr == ADDR_MASK ? 32'(maskQ) :
    regAddr == ADDR_TERM ? termWord :
    regAddr == ADDR_RSTCOUNT ? 32'(rstCountQ) : codeWord;

  // Frequency detection settings.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      levelQ <= FREQ_RST;
      widthQ <= FREQ_RST;
      detSelQ <= DETSEL_RST; // RL6
    end else if (ce) begin
      if (wrLevel) begin
        levelQ <= regWdata[FW-1:0]; // RL4
      end
      if (wrWidth) begin
        widthQ <= regWdata[FW-1:0];
      end
      if (wrDetSel) begin
        detSelQ <= regWdata[0]; // RL6
      end
    end
  end

  // Torque detection settings.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tqSelQ <= TQSEL_RST;
      tqLevelQ <= FREQ_RST;
      tqTimeQ <= FREQ_RST;
    end else if (ce) begin
      if (wrTqSel) begin
        tqSelQ <= regWdata[3:0]; // RL9
      end
      if (wrTqLevel) begin
        tqLevelQ <= regWdata[FW-1:0]; // RL8
      end
      if (wrTqTime) begin
        tqTimeQ <= regWdata[FW-1:0]; // RL8
      end
    end
  end

  // Restart attempt limit and interrupt mask.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstLimitQ <= RSTLIMIT_RST;
      maskQ <= {STAT_W{1'b0}};
    end else if (ce) begin
      if (wrRstLimit) begin
        rstLimitQ <= regWdata[7:0]; // RL14
      end
      if (wrMask) begin
        maskQ <= regWdata[STAT_W-1:0];
      end
    end
  end

  // Sticky status and the level interrupt; irq looks at the next status so it
  // follows a set or a clear in the same cycle as the status register does.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      statusQ <= {STAT_W{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      statusQ <= statusD;
      irq <= |(statusD & maskQ);
    end
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 32'h00000000;
    end else if (ce) begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

  // Frequency detection hysteresis, re-evaluated every control cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      freq3OffQ <= 1'b0;
      freq4OnQ <= 1'b0;
    end else if (ce) begin
      freq3OffQ <= freq3OffD; // RL5
      freq4OnQ <= freq4OnD; // RL7
    end
  end

  // Torque detection with its millisecond qualifier. The counter saturates so a
  // long undertorque spell cannot wrap round and drop the flag.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tq2Q <= 1'b0;
      prescQ <= 17'h00000;
      msCountQ <= FREQ_RST;
    end else if (ce) begin
      tq2Q <= tq2D; // RL8
      prescQ <= (!tqLow || msTick) ? 17'h00000 : prescQ + 17'h00001;
      if (!tqLow) begin
        msCountQ <= FREQ_RST;
      end else if (msTick && msCountQ != 16'hFFFF) begin
        msCountQ <= msCountQ + 16'h0001; // RL9
      end
    end
  end

  // Rotation direction.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reverseQ <= 1'b0;
    end else if (ce) begin
      reverseQ <= reverseD; // RL10
    end
  end

  // Fault restart sequencer state and attempt count.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstStateQ <= RS_IDLE;
      rstCountQ <= 8'h00;
    end else if (ce) begin
      rstStateQ <= rstStateD; // RL12
      rstCountQ <= rstCountD; // RL14
    end
  end

endmodule : otss_top
